// ### common/prc_params.svh
// constants for the port reset configuration block
//
// Overview of operation
// - pins reset to floating input, no pulls, except return clock P0.13 driven
// - P1[19:16], P0.13 reset as debug functions
// - debug inputs float and work without setup
// - debug data out driven only while shifting
// - return clock always drives push-pull
// - return clock low during device reset
// - return clock is three-stage resynchronized input
// - config registers never select debug functions
// - boot straps P0.11, P0.0 sampled before fetch
// - serial-memory boot enables P0.4-7 functions
// - chip selects 1-3 stay floating inputs
`ifndef PRC_PARAMS_SVH
`define PRC_PARAMS_SVH

`define PRC_P0_W 32
`define PRC_P1_W 20
`define PRC_P2_W 20

// register map: one block of four words per port, then boot status
`define PRC_PORT_STRIDE 8'h10
`define PRC_OFS_OE 4'h0
`define PRC_OFS_PULL 4'h4
`define PRC_OFS_OUT 4'h8
`define PRC_OFS_IN 4'hc
`define PRC_OFS_BOOT 8'h30
`define PRC_RST_OE 32'h0000_0000
`define PRC_RST_PULL 32'h0000_0000
`define PRC_RST_OUT 32'h0000_0000

// boot status fields
`define PRC_BOOT_STRAP0_BIT 0
`define PRC_BOOT_STRAP11_BIT 1
`define PRC_BOOT_DONE_BIT 4
`define PRC_BOOT_SERMEM_BIT 5
// strap pattern {p0.11, p0.0} that selects serial-memory boot
`define PRC_BOOT_SERMEM_CODE 2'b10

// pin positions
`define PRC_STRAP0_PIN 0
`define PRC_STRAP11_PIN 11
`define PRC_RCLK_PIN 13
`define PRC_DBG_DIN_PIN 16
`define PRC_DBG_DOUT_PIN 17
`define PRC_DBG_CLK_PIN 18
`define PRC_DBG_MODE_PIN 19
`define PRC_SM_SEL0_PIN 4
`define PRC_SM_CLK_PIN 5
`define PRC_SM_DIN_PIN 6
`define PRC_SM_DOUT_PIN 7

// timing
`define PRC_SYNC_STAGES 2
`define PRC_RCLK_STAGES 3
// wait-counter value that ends the wait after release, so straps are read on the fourth edge: input sync latency
`define PRC_STRAP_WAIT 2'd2

`endif

// ### common/prc_pkg.sv
// types shared by the port reset configuration block
`default_nettype none
package prc_pkg;
    typedef logic [31:0] prc_word_t;
    typedef enum logic [1:0] {
        PRC_BOOT_WAIT = 2'b00,
        PRC_BOOT_SAMPLE = 2'b01,
        PRC_BOOT_DONE = 2'b10
    } prc_boot_e;
    typedef struct packed {
        logic strap11;
        logic strap0;
    } prc_straps_s;
endpackage
`default_nettype wire

// ### common/prc_dbg_if.sv
// debug clock carrier between top and return-clock synchronizer
`default_nettype none
interface prc_dbg_if;
    logic debug_clock_in;
    logic debug_return_clock;
    modport sync (input debug_clock_in, output debug_return_clock);
    modport top (output debug_clock_in, input debug_return_clock);
endinterface
`default_nettype wire

// ### hw/prc_rclk_sync.sv
// return-clock resynchronizer on the system clock
`include "prc_params.svh"
`default_nettype none
module prc_rclk_sync (
    input wire logic clk, // system clock
    input wire logic rst_n, // device reset, async active low
    prc_dbg_if.sync dbg // debug clock in, return clock out
);
    import prc_pkg::*;

    logic [`PRC_RCLK_STAGES-1:0] stage_ff;

    // the async clear keeps the output low for the whole reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_ff <= '0;
        end else begin
            stage_ff <= {stage_ff[`PRC_RCLK_STAGES-2:0], dbg.debug_clock_in};
        end
    end

    assign dbg.debug_return_clock = stage_ff[`PRC_RCLK_STAGES-1];
endmodule // prc_rclk_sync
`default_nettype wire

// ### hw/prc_top.sv
// port reset configuration: pin mux, boot straps and register file
//
// The APB slave port and the register addresses were left to the implementer.
`include "prc_params.svh"
`default_nettype none
module prc_top (
    input wire logic clk, // system clock, 100 MHz
    input wire logic rst_n, // device reset, async active low
    // apb slave
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    // pads
    input wire logic [`PRC_P0_W-1:0] p0_in, // port 0 pad levels
    output logic [`PRC_P0_W-1:0] p0_out, // port 0 pad drive value
    output logic [`PRC_P0_W-1:0] p0_oe, // port 0 pad output enable
    output logic [`PRC_P0_W-1:0] p0_pull, // port 0 weak pull enable
    input wire logic [`PRC_P1_W-1:0] p1_in, // port 1 pad levels
    output logic [`PRC_P1_W-1:0] p1_out, // port 1 pad drive value
    output logic [`PRC_P1_W-1:0] p1_oe, // port 1 pad output enable
    output logic [`PRC_P1_W-1:0] p1_pull, // port 1 weak pull enable
    input wire logic [`PRC_P2_W-1:0] p2_in, // port 2 pad levels
    output logic [`PRC_P2_W-1:0] p2_out, // port 2 pad drive value
    output logic [`PRC_P2_W-1:0] p2_oe, // port 2 pad output enable
    output logic [`PRC_P2_W-1:0] p2_pull, // port 2 weak pull enable
    // debug link
    input wire logic debug_clock_in, // debug clock, link domain
    output logic debug_data_in, // to tap: data in pad
    output logic debug_mode_select, // to tap: mode select pad
    input wire logic tap_data_out, // from tap, link domain
    input wire logic tap_shifting, // from tap: shift-out in progress
    // serial memory interface
    input wire logic sermem_data_out, // memory controller data out
    input wire logic sermem_clock, // memory controller clock out
    input wire logic sermem_select0, // memory controller chip select 0
    output logic sermem_data_in, // data in from pad
    // boot
    output logic boot_sermem, // straps select serial-memory boot
    output prc_pkg::prc_straps_s boot_straps, // held strap levels
    output logic cpu_fetch_en // cpu may fetch from address zero
);
    import prc_pkg::*;

    localparam int NPORT = 3;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [1:0] port_of(input logic [7:0] a);
        port_of = a[5:4];
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        // upper address bits decoded too, so no port aliases at 0x40 and up
        mapped = (a[1:0] == 2'b00) && (a[7:6] == 2'b00) &&
                 ((32'(port_of(a)) < NPORT) || (a == `PRC_OFS_BOOT));
    endfunction

    function automatic prc_word_t width_mask(input logic [1:0] p);
        case (p)
            2'd0: width_mask = prc_word_t'({`PRC_P0_W{1'b1}});
            2'd1: width_mask = {{(32-`PRC_P1_W){1'b0}}, {`PRC_P1_W{1'b1}}};
            2'd2: width_mask = {{(32-`PRC_P2_W){1'b0}}, {`PRC_P2_W{1'b1}}};
            default: width_mask = '0;
        endcase
    endfunction

    function automatic logic sermem_decode(input prc_straps_s s);
        sermem_decode = ({s.strap11, s.strap0} == `PRC_BOOT_SERMEM_CODE);
    endfunction

    // ------------------------------------------------------------------
    // pad input synchronizers
    // ------------------------------------------------------------------
    prc_word_t pad_raw [NPORT];
    prc_word_t sync1_ff [NPORT];
    prc_word_t sync2_ff [NPORT];

    assign pad_raw[0] = 32'(p0_in);
    assign pad_raw[1] = 32'(p1_in);
    assign pad_raw[2] = 32'(p2_in);

    genvar gp;
    generate
        for (gp = 0; gp < NPORT; gp++) begin : g_sync
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync1_ff[gp] <= '0;
                    sync2_ff[gp] <= '0;
                end else begin
                    sync1_ff[gp] <= pad_raw[gp];
                    sync2_ff[gp] <= sync1_ff[gp];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // boot strap capture
    // ------------------------------------------------------------------
    prc_boot_e boot_state_ff;
    prc_boot_e nxt_boot_state;
    logic [1:0] wait_cnt_ff;
    prc_straps_s straps_ff;
    logic sermem_ff;

    // straps are read only after the synchronizers have filled with
    // post-reset pad levels, and before the cpu is let go
    always_comb begin
        nxt_boot_state = boot_state_ff;
        case (boot_state_ff)
            PRC_BOOT_WAIT: begin
                if (wait_cnt_ff == `PRC_STRAP_WAIT) begin
                    nxt_boot_state = PRC_BOOT_SAMPLE;
                end
            end
            PRC_BOOT_SAMPLE: nxt_boot_state = PRC_BOOT_DONE;
            PRC_BOOT_DONE: nxt_boot_state = PRC_BOOT_DONE;
            default: nxt_boot_state = PRC_BOOT_WAIT;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_state_ff <= PRC_BOOT_WAIT;
        end else begin
            boot_state_ff <= nxt_boot_state;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_cnt_ff <= 2'd0;
        end else if (boot_state_ff == PRC_BOOT_WAIT) begin
            wait_cnt_ff <= wait_cnt_ff + 2'd1;
        end
    end

    // captured once; later gpio use of the pins cannot move them
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            straps_ff <= '0;
            sermem_ff <= 1'b0;
        end else if (boot_state_ff == PRC_BOOT_SAMPLE) begin
            straps_ff.strap0 <= sync2_ff[0][`PRC_STRAP0_PIN];
            straps_ff.strap11 <= sync2_ff[0][`PRC_STRAP11_PIN];
            sermem_ff <= sermem_decode('{strap11: sync2_ff[0][`PRC_STRAP11_PIN],
                                         strap0: sync2_ff[0][`PRC_STRAP0_PIN]});
        end
    end

    assign boot_straps = straps_ff;
    assign boot_sermem = sermem_ff;
    assign cpu_fetch_en = (boot_state_ff == PRC_BOOT_DONE);

    // ------------------------------------------------------------------
    // port configuration registers
    // ------------------------------------------------------------------
    prc_word_t oe_ff [NPORT];
    prc_word_t pull_ff [NPORT];
    prc_word_t out_ff [NPORT];
    logic wr_en;
    logic setup;

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite;

    // same reset for every bit, debug pins included
    generate
        for (gp = 0; gp < NPORT; gp++) begin : g_regs
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    oe_ff[gp] <= `PRC_RST_OE;
                    pull_ff[gp] <= `PRC_RST_PULL;
                    out_ff[gp] <= `PRC_RST_OUT;
                end else if (wr_en && mapped(paddr) && (32'(port_of(paddr)) == gp)) begin
                    case (paddr[3:0])
                        `PRC_OFS_OE: oe_ff[gp] <= pwdata & width_mask(2'(gp));
                        `PRC_OFS_PULL: pull_ff[gp] <= pwdata & width_mask(2'(gp));
                        `PRC_OFS_OUT: out_ff[gp] <= pwdata & width_mask(2'(gp));
                        default: ;
                    endcase
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // apb read path
    // ------------------------------------------------------------------
    logic [31:0] prdata_ff;
    prc_word_t rd_word;
    prc_word_t boot_word;

    always_comb begin
        boot_word = '0;
        boot_word[`PRC_BOOT_STRAP0_BIT] = straps_ff.strap0;
        boot_word[`PRC_BOOT_STRAP11_BIT] = straps_ff.strap11;
        boot_word[`PRC_BOOT_DONE_BIT] = (boot_state_ff == PRC_BOOT_DONE);
        boot_word[`PRC_BOOT_SERMEM_BIT] = sermem_ff;
    end

    always_comb begin
        rd_word = '0;
        if (paddr == `PRC_OFS_BOOT) begin
            rd_word = boot_word;
        end else if (mapped(paddr)) begin
            case (paddr[3:0])
                `PRC_OFS_OE: rd_word = oe_ff[port_of(paddr)];
                `PRC_OFS_PULL: rd_word = pull_ff[port_of(paddr)];
                `PRC_OFS_OUT: rd_word = out_ff[port_of(paddr)];
                `PRC_OFS_IN: rd_word = sync2_ff[port_of(paddr)];
                default: rd_word = '0;
            endcase
        end
    end

    // read data is registered in the setup cycle so it stands in access
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_ff <= '0;
        end else if (setup && !pwrite) begin
            prdata_ff <= rd_word;
        end
    end

    assign prdata = prdata_ff;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);

    // ------------------------------------------------------------------
    // debug link domain: data-out driver
    // ------------------------------------------------------------------
    logic dout_ff;
    logic dout_en_ff;

    // updated on the falling debug clock edge as the probe expects;
    // the clock may stop, so reset is asserted without it
    always_ff @(negedge debug_clock_in or negedge rst_n) begin
        if (!rst_n) begin
            dout_ff <= 1'b0;
            dout_en_ff <= 1'b0;
        end else begin
            dout_ff <= tap_data_out;
            dout_en_ff <= tap_shifting;
        end
    end

    // ------------------------------------------------------------------
    // return clock
    // ------------------------------------------------------------------
    prc_dbg_if dbg_bus ();
    logic rclk;

    assign dbg_bus.debug_clock_in = debug_clock_in;
    assign rclk = dbg_bus.debug_return_clock;

    prc_rclk_sync u_rclk (
        .clk (clk),
        .rst_n (rst_n),
        .dbg (dbg_bus.sync)
    );

    // ------------------------------------------------------------------
    // pad mux
    // ------------------------------------------------------------------
    prc_word_t mux_out [NPORT];
    prc_word_t mux_oe [NPORT];
    prc_word_t mux_pull [NPORT];

    // debug pins ignore the config registers, except the out register on the three debug input pins
    always_comb begin
        for (int i = 0; i < NPORT; i++) begin
            mux_out[i] = out_ff[i];
            mux_oe[i] = oe_ff[i];
            mux_pull[i] = pull_ff[i];
        end
        // port 1 debug group
        mux_oe[1][`PRC_DBG_DIN_PIN] = 1'b0;
        mux_pull[1][`PRC_DBG_DIN_PIN] = 1'b0;
        mux_oe[1][`PRC_DBG_MODE_PIN] = 1'b0;
        mux_pull[1][`PRC_DBG_MODE_PIN] = 1'b0;
        mux_oe[1][`PRC_DBG_CLK_PIN] = 1'b0;
        mux_pull[1][`PRC_DBG_CLK_PIN] = 1'b0;
        mux_out[1][`PRC_DBG_DOUT_PIN] = dout_ff;
        mux_oe[1][`PRC_DBG_DOUT_PIN] = dout_en_ff;
        mux_pull[1][`PRC_DBG_DOUT_PIN] = 1'b0;
        // return clock pin always push-pull
        mux_out[0][`PRC_RCLK_PIN] = rclk;
        mux_oe[0][`PRC_RCLK_PIN] = 1'b1;
        mux_pull[0][`PRC_RCLK_PIN] = 1'b0;
        // serial memory only on that boot; selects 1-3 untouched
        if (sermem_ff) begin
            mux_out[0][`PRC_SM_DOUT_PIN] = sermem_data_out;
            mux_oe[0][`PRC_SM_DOUT_PIN] = 1'b1;
            mux_out[0][`PRC_SM_CLK_PIN] = sermem_clock;
            mux_oe[0][`PRC_SM_CLK_PIN] = 1'b1;
            mux_out[0][`PRC_SM_SEL0_PIN] = sermem_select0;
            mux_oe[0][`PRC_SM_SEL0_PIN] = 1'b1;
            mux_oe[0][`PRC_SM_DIN_PIN] = 1'b0;
            mux_pull[0][`PRC_SM_DOUT_PIN] = 1'b0;
            mux_pull[0][`PRC_SM_CLK_PIN] = 1'b0;
            mux_pull[0][`PRC_SM_SEL0_PIN] = 1'b0;
            mux_pull[0][`PRC_SM_DIN_PIN] = 1'b0;
        end
    end

    assign p0_out = mux_out[0][`PRC_P0_W-1:0];
    assign p0_oe = mux_oe[0][`PRC_P0_W-1:0];
    assign p0_pull = mux_pull[0][`PRC_P0_W-1:0];
    assign p1_out = mux_out[1][`PRC_P1_W-1:0];
    assign p1_oe = mux_oe[1][`PRC_P1_W-1:0];
    assign p1_pull = mux_pull[1][`PRC_P1_W-1:0];
    assign p2_out = mux_out[2][`PRC_P2_W-1:0];
    assign p2_oe = mux_oe[2][`PRC_P2_W-1:0];
    assign p2_pull = mux_pull[2][`PRC_P2_W-1:0];

    // the tap samples its own inputs on its clock, so no sync here
    assign debug_data_in = p1_in[`PRC_DBG_DIN_PIN];
    assign debug_mode_select = p1_in[`PRC_DBG_MODE_PIN];
    // serial data in goes through the pad synchronizer
    assign sermem_data_in = sync2_ff[0][`PRC_SM_DIN_PIN];
endmodule // prc_top
`default_nettype wire

// ### verification/prc_checker.sv
// assertions on the pin mux, return clock and boot strap outputs
`include "prc_params.svh"
`default_nettype none
module prc_checker (
    input wire logic clk, // system clock
    input wire logic rst_n, // device reset
    input wire logic [`PRC_P0_W-1:0] p0_out, // port 0 drive
    input wire logic [`PRC_P0_W-1:0] p0_oe, // port 0 enable
    input wire logic [`PRC_P0_W-1:0] p0_pull, // port 0 pulls
    input wire logic [`PRC_P1_W-1:0] p1_in, // port 1 levels
    input wire logic [`PRC_P1_W-1:0] p1_out, // port 1 drive
    input wire logic [`PRC_P1_W-1:0] p1_oe, // port 1 enable
    input wire logic [`PRC_P1_W-1:0] p1_pull, // port 1 pulls
    input wire logic debug_clock_in, // link clock
    input wire logic debug_data_in, // tap data in
    input wire logic debug_mode_select, // tap mode select
    input wire logic tap_data_out, // tap shift data
    input wire logic tap_shifting, // tap shift request
    input wire logic sermem_data_out, // memory data out
    input wire logic sermem_clock, // memory clock
    input wire logic sermem_select0, // memory select 0
    input wire logic boot_sermem, // serial-memory boot
    input wire prc_pkg::prc_straps_s boot_straps, // held straps
    input wire logic cpu_fetch_en // fetch allowed
);
    import prc_pkg::*;
    // ----------------------------------------
    // edges since release, saturating so it never wraps into a false window
    // ----------------------------------------
    logic [2:0] rel_cnt_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rel_cnt_ff <= 3'h0;
        end else if (rel_cnt_ff != 3'h7) begin
            rel_cnt_ff <= rel_cnt_ff + 3'h1;
        end
    end
    a_rclk_rst_low: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> !$past(p0_out[13])) else $error("return clock high in reset");
    a_reset_state: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> $past(p0_oe) == 32'h0000_2000) else $error("port 0 reset enables");
    a_rclk_follow: assert property (@(posedge clk) disable iff (!rst_n)
        rel_cnt_ff >= 3'h3 |-> p0_out[13] == $past(debug_clock_in, 3))
        else $error("return clock not three stages behind");
    a_rclk_drive: assert property (@(posedge clk) disable iff (!rst_n)
        p0_oe[13] && !p0_pull[13]) else $error("return clock not driven");
    a_dbg_in_float: assert property (@(posedge clk) disable iff (!rst_n)
        p1_oe[16] == 1'b0 && p1_oe[19:18] == 2'h0 && p1_pull[19:16] == 4'h0)
        else $error("debug input not floating");
    a_dbg_in_copy: assert property (@(posedge clk) disable iff (!rst_n)
        debug_data_in == p1_in[16] && debug_mode_select == p1_in[19])
        else $error("debug inputs not passed on");
    a_dout_enable: assert property (@(negedge debug_clock_in) disable iff (!rst_n)
        p1_oe[17] == $past(tap_shifting)) else $error("data out enable wrong");
    a_dout_value: assert property (@(negedge debug_clock_in) disable iff (!rst_n)
        $past(tap_shifting) |-> p1_out[17] == $past(tap_data_out)) else $error("data out bit");
    a_fetch_order: assert property (@(posedge clk) disable iff (!rst_n)
        cpu_fetch_en == (rel_cnt_ff >= 3'h4)) else $error("fetch enable timing");
    a_boot_code: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(cpu_fetch_en) |-> boot_sermem == (boot_straps == 2'b10))
        else $error("boot mode decode");
    a_straps_held: assert property (@(posedge clk) disable iff (!rst_n)
        cpu_fetch_en && $past(cpu_fetch_en) |-> $stable(boot_straps) && $stable(boot_sermem))
        else $error("straps changed");
    a_sermem_pins: assert property (@(posedge clk) disable iff (!rst_n)
        boot_sermem |-> p0_oe[7:4] == 4'hb && p0_pull[7:4] == 4'h0 && p0_out[7] ==
        sermem_data_out && p0_out[5] == sermem_clock && p0_out[4] == sermem_select0)
        else $error("serial memory pins");
    c_fetch: cover property (@(posedge clk) $rose(cpu_fetch_en));
    c_sermem: cover property (@(posedge clk) $rose(boot_sermem));
    c_shift: cover property (@(negedge debug_clock_in) tap_shifting);
endmodule // prc_checker
bind prc_top prc_checker chk_u (.clk, .rst_n, .p0_out, .p0_oe, .p0_pull, .p1_in, .p1_out,
    .p1_oe, .p1_pull, .debug_clock_in, .debug_data_in, .debug_mode_select, .tap_data_out,
    .tap_shifting, .sermem_data_out, .sermem_clock, .sermem_select0, .boot_sermem,
    .boot_straps, .cpu_fetch_en);
`default_nettype wire

// ### verification/prc_probe.sv
// debug probe and board strap model for the port reset block
`default_nettype none
module prc_probe (
    output logic debug_clock_in = 1'b0, // link clock, still between frames
    output logic tap_data_out = 1'b0, // shift data seen by the tap
    output logic tap_shifting = 1'b0, // shift-out request seen by the tap
    output logic [1:0] strap = 2'b00 // board levels on p0.11 and p0.0
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // one 6 ns link cycle a call; clock rests low between calls
    // ----------------------------------------
    // declaration values: no false falling link edge at time zero
    task automatic set_straps(input logic [1:0] v);
        strap <= v;
    endtask
    task automatic shift_bit(input logic d, input logic sh);
        debug_clock_in = 1'b1;
        tap_shifting = sh;
        // an idle data line is not left at its last level
        tap_data_out = sh ? d : ~tap_data_out;
        #3 debug_clock_in = 1'b0;
        #3;
    endtask
endmodule // prc_probe
`default_nettype wire

// ### verification/prc_top_tb.sv
// self-checking bench for the port reset configuration block
`include "prc_params.svh"
`default_nettype none
module prc_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import prc_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, debug_clock_in, tap_data_out;
    logic tap_shifting, sermem_data_out, sermem_clock, sermem_select0, sermem_data_in;
    logic debug_data_in, debug_mode_select, boot_sermem, cpu_fetch_en;
    logic [7:0] paddr, a;
    logic [31:0] pwdata, prdata, rnd, pad_ext, p0_in, p0_out, p0_oe, p0_pull;
    logic [`PRC_P1_W-1:0] p1_in, p1_out, p1_oe, p1_pull, p2_in, p2_out, p2_oe, p2_pull, seen;
    logic [1:0] strap;
    prc_straps_s boot_straps;
    logic [32:0] exp_q[$];
    int err_count, samples_checked;
    // pad levels: driven bits read back, others from the board
    assign p0_in = (p0_oe & p0_out) | (~p0_oe & {pad_ext[31:12], strap[1], pad_ext[10:1], strap[0]});
    assign p1_in = (p1_oe & p1_out) | (~p1_oe & pad_ext[19:0]);
    assign p2_in = (p2_oe & p2_out) | (~p2_oe & ~pad_ext[19:0]);
    prc_top dut_u (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .p0_in, .p0_out, .p0_oe, .p0_pull, .p1_in, .p1_out, .p1_oe, .p1_pull, .p2_in,
        .p2_out, .p2_oe, .p2_pull, .debug_clock_in, .debug_data_in, .debug_mode_select,
        .tap_data_out, .tap_shifting, .sermem_data_out, .sermem_clock, .sermem_select0,
        .sermem_data_in, .boot_sermem, .boot_straps, .cpu_fetch_en);
    prc_probe prb_u (.debug_clock_in, .tap_data_out, .tap_shifting, .strap);
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, got);
        end
    endtask
    task automatic complete_run();
        if (err_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // one idle edge before each setup keeps every strobe to one assignment per step
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d,
        input logic [32:0] e);
        @(posedge clk);
        if (!wr) exp_q.push_back(e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic do_reset(input logic [1:0] st);
        @(posedge clk);
        rst_n <= 1'b0;
        prb_u.set_straps(st);
        repeat (8) @(posedge clk);
        check("rst p0_oe", p0_oe, 32'h0000_2000);
        check("rst rclk", p0_out[13], 1'b0);
        check("rst float", |{p0_pull, p1_oe, p1_pull, p2_oe, p2_pull}, 1'b0);
        check("rst fetch", cpu_fetch_en, 1'b0);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1 check("fetch early", cpu_fetch_en, 1'b0);
        @(posedge clk);
        #1 check("fetch", cpu_fetch_en, 1'b1);
    endtask
    // read monitor: oldest note against what the slave answers
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite) begin
            if (exp_q.size() == 0) begin
                check("unexpected read", 32'h1, 32'h0);
            end else begin
                check("prdata", prdata, exp_q[0][31:0]);
                check("pslverr", pslverr, exp_q[0][32]);
                void'(exp_q.pop_front());
            end
        end
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #50000;
        err_count++;
        complete_run();
    end
    initial begin
        rst_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {sermem_data_out, sermem_clock, sermem_select0} = 3'h0;
        pad_ext = 32'h0;
        rnd = 32'h0000_000e;
        do_reset(2'b10);
        check("boot_sermem", boot_sermem, 1'b1);
        check("boot_straps", boot_straps, 2'b10);
        check("p0_oe sermem", p0_oe[12:4], 9'h00b);
        apb(1'b0, 8'h30, 32'h0, 33'h0_0000_0032);
        repeat (4) begin
            @(posedge clk);
            {sermem_data_out, sermem_clock, sermem_select0} <= rnd[2:0];
            pad_ext <= rnd;
            rnd = lfsr(rnd);
        end
        #1 prb_u.set_straps(2'b01);
        repeat (6) @(posedge clk);
        #1 check("held straps", boot_straps, 2'b10);
        check("sermem din", sermem_data_in, pad_ext[6]);
        do_reset(2'b00);
        check("boot_sermem", boot_sermem, 1'b0);
        check("p0_oe", p0_oe, 32'h0000_2000);
        apb(1'b0, 8'h00, 32'h0, 33'h0);
        apb(1'b0, 8'h10, 32'h0, 33'h0);
        apb(1'b0, 8'h14, 32'h0, 33'h0);
        apb(1'b1, 8'h10, 32'hffff_ffff, 33'h0);
        apb(1'b1, 8'h00, 32'h0, 33'h0);
        apb(1'b0, 8'h10, 32'h0, 33'h0_000f_ffff);
        apb(1'b0, 8'h34, 32'h0, 33'h1_0000_0000);
        apb(1'b0, 8'h40, 32'h0, 33'h1_0000_0000);
        #1 check("p1_oe", p1_oe, 20'h0ffff);
        check("p0_oe", p0_oe, 32'h0000_2000);
        for (int k = 0; k < 6; k++) begin
            a = 8'h20 + 8'(4 * (k % 3));
            apb(1'b1, a, rnd, 33'h0);
            apb(1'b0, a, 32'h0, {13'h0, rnd[19:0]});
            seen = (k % 3 == 0) ? p2_oe : (k % 3 == 1) ? p2_pull : p2_out;
            #1 check("port 2 pads", seen, rnd[19:0]);
            rnd = lfsr(rnd);
        end
        // frame starts off the system clock edge so no edges coincide
        @(posedge clk);
        #1.5;
        for (int i = 0; i < 8; i++) begin
            prb_u.shift_bit(rnd[i], 1'b1);
            check("dout oe", p1_oe[17], 1'b1);
            check("dout", p1_out[17], rnd[i]);
        end
        prb_u.shift_bit(1'b0, 1'b0);
        check("dout idle", p1_oe[17], 1'b0);
        complete_run();
    end
endmodule // prc_top_tb
`default_nettype wire
